// ### fp_exception_status_test.sv
`timescale 1ns/100ps
module fp_exception_status_test;
    import fpexc_pkg::*;
    typedef struct packed {
        logic [4:0] en;
        logic [1:0] tm;
        logic [11:0] cond;
        logic sup;
        logic wrr;
        logic trp;
        logic asst;
        logic [31:0] word;
    } fpexc_row_s;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic mclk, rst, wr_en, valid, fr, fi, sync, tiny, older, younger;
    logic [31:0] wr_data, wr_mask, rd_data;
    logic [11:0] cond;
    logic [1:0] tm, rmode;
    logic [3:0] lag;
    fpexc_class_e cls;
    logic sup, wres, trp, hold, assist, nieee, sdn, c_sup, c_wr, c_trp;
    int errors, num_checks;
    // enables {invalid, overflow, underflow, zero divide, inexact}, trap mode,
    // conditions, expected outputs and word
    fpexc_row_s rows [8] = '{
        '{5'h02, 2'h1, 12'h004, 1'b1, 1'b0, 1'b1, 1'b1, 32'hc4000010},
        '{5'h00, 2'h1, 12'h004, 1'b0, 1'b1, 1'b0, 1'b0, 32'h84000000},
        '{5'h10, 2'h1, 12'h800, 1'b1, 1'b0, 1'b1, 1'b1, 32'he0000180},
        '{5'h08, 2'h1, 12'h009, 1'b0, 1'b1, 1'b1, 1'b1, 32'hd2000040},
        '{5'h04, 2'h2, 12'h00a, 1'b0, 1'b1, 1'b1, 1'b1, 32'hca000020},
        '{5'h00, 2'h3, 12'h110, 1'b0, 1'b1, 1'b0, 1'b0, 32'ha1100000},
        '{5'h10, 2'h1, 12'h210, 1'b1, 1'b0, 1'b1, 1'b1, 32'he1080080},
        '{5'h01, 2'h1, 12'h400, 1'b0, 1'b1, 1'b0, 1'b0, 32'ha0000208}};
    logic [4:0] codes [9] = '{5'h11, 5'h09, 5'h08, 5'h18, 5'h12, 5'h02, 5'h14, 5'h04, 5'h05};

    fpexc_top u_fpexc_top (.MCLK_I(mclk), .RESET_I(rst), .WR_EN_I(wr_en),
        .WR_DATA_I(wr_data), .WR_MASK_I(wr_mask), .RD_DATA_O(rd_data),
        .INSTR_VALID_I(valid), .EXC_COND_I(cond), .RESULT_CLASS_I(cls),
        .FRAC_ROUNDED_I(fr), .FRAC_INEXACT_I(fi), .SYNC_I(sync), .STORE_TINY_I(tiny),
        .TRAP_MODE_I(tm), .OLDER_DONE_I(older), .YOUNGER_IDLE_I(younger),
        .SUPPRESS_O(sup), .WRITE_RESULT_O(wres), .TRAP_RESULT_O(trp),
        .HOLD_YOUNGER_O(hold), .ASSIST_EXC_O(assist), .ROUND_MODE_O(rmode),
        .NON_IEEE_O(nieee), .STORE_DENORM_O(sdn));

    fpexc_pipe_model u_fpexc_pipe_model (.clk_i(mclk), .reset_i(rst), .hold_i(hold),
        .lag_i(lag), .older_done_o(older), .younger_idle_o(younger));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one masked write; strobe spans exactly one rising edge
    task automatic wr(input logic [31:0] d, input logic [31:0] m);
        @(negedge mclk);
        wr_en = 1'b1;
        wr_data = d;
        wr_mask = m;
        @(negedge mclk);
        wr_en = 1'b0;
    endtask

    // one completing instruction; combinational answers caught mid-cycle
    task automatic instr(input logic [11:0] c);
        @(negedge mclk);
        valid = 1'b1;
        cond = c;
        #1;
        c_sup = sup;
        c_wr = wres;
        c_trp = trp;
        @(negedge mclk);
        valid = 1'b0;
        cond = 12'h000;
    endtask

    task automatic do_row(input fpexc_row_s r);
        int n;
        logic prev;
        tm = r.tm;
        wr({24'h0, r.en, 3'h0}, 32'hffffffff);
        instr(r.cond);
        chk(c_sup, r.sup);
        chk(c_wr, r.wrr);
        chk(c_trp, r.trp);
        chk(rd_data & 32'hfff807f8, r.word);
        chk(hold, r.asst);
        n = 0;
        prev = older;
        repeat (10) begin
            @(negedge mclk);
            if (assist === 1'b1) begin
                n++;
                chk(prev, 1'b1);
            end
            prev = older;
        end
        chk(n, r.asst);
        instr(12'h000);
        chk(rd_data & 32'hfff807f8, r.word);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        errors++;
        complete_run();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        {wr_en, valid, fr, fi, sync, tiny} = 6'h00;
        {wr_data, wr_mask, cond, tm, lag} = '0;
        cls = FPEXC_POS_NORM;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        chk(rd_data, 32'h00000000);
        foreach (rows[i]) do_row(rows[i]);
        // rounding field and non-ieee select, every mode
        for (int m = 0; m < 4; m++) begin
            wr({29'h0, 1'b1, m[1:0]}, 32'h00000007);
            chk(rmode, m[1:0]);
            chk(nieee, 1'b1);
        end
        wr(32'h0, 32'h4);
        chk(nieee, 1'b0);
        // computed summaries refuse writes; any summary takes a write
        wr(32'h60000000, 32'hffffffff);
        chk(rd_data & 32'he0000000, 32'h0);
        wr(32'h80000000, 32'h80000000);
        chk(rd_data[31], 1'b1);
        // every result class code
        {fr, fi} = 2'h3;
        for (int k = 0; k < 9; k++) begin
            cls = fpexc_class_e'(k);
            instr(12'h000);
            chk(rd_data[16:12], codes[k]);
            chk(rd_data[18:17], 2'h3);
        end
        // store denormalisation ignores the underflow enable
        wr(32'h20, 32'h20);
        tiny = 1'b1;
        #1 chk(sdn, 1'b1);
        tiny = 1'b0;
        #1 chk(sdn, 1'b0);
        // slow pipeline: handler only after drain
        lag = 4'h4;
        do_row(rows[0]);
        lag = 4'h0;
        // ignore mode defers flags until sync and never arms the handler
        tm = 2'h0;
        wr(32'h10, 32'hffffffff);
        // a delivered result first, so the suppressed one visibly clears rounding bits
        instr(12'h000);
        instr(12'h004);
        chk(c_sup, 1'b1);
        chk(rd_data & 32'hfc000000, 32'h0);
        chk(rd_data[18:17], 2'h0);
        repeat (4) @(negedge mclk);
        chk({hold, assist}, 2'h0);
        @(negedge mclk);
        sync = 1'b1;
        @(negedge mclk);
        sync = 1'b0;
        chk(rd_data & 32'hfff807f8, 32'hc4000010);
        // second reset in mid-run
        rst = 1'b1;
        @(negedge mclk);
        chk(rd_data, 32'h00000000);
        rst = 1'b0;
        // first instruction after the release must record normally
        tm = 2'h1;
        instr(12'h001);
        chk(rd_data & 32'hfff807f8, 32'h90000000);
        chk(hold, 1'b0);
        complete_run();
    end
endmodule

// ### fpexc_class_enc.sv
`timescale 1ns/100ps
module fpexc_class_enc (
    input wire fpexc_pkg::fpexc_class_e class_i,
    output logic [4:0] code_o
);
    import fpexc_pkg::*;

    // ------------------------------------------------------------
    // result class to five-bit flag code
    // ------------------------------------------------------------
    always_comb begin
        unique case (class_i)
            FPEXC_QNAN: code_o = CLS_QNAN;
            FPEXC_NEG_INF: code_o = CLS_NEG_INF;
            FPEXC_POS_INF: code_o = CLS_POS_INF;
            FPEXC_NEG_NORM: code_o = CLS_NEG_NORM;
            FPEXC_NEG_DENORM: code_o = CLS_NEG_DENORM;
            FPEXC_POS_DENORM: code_o = CLS_POS_DENORM;
            FPEXC_NEG_ZERO: code_o = CLS_NEG_ZERO;
            FPEXC_POS_ZERO: code_o = CLS_POS_ZERO;
            FPEXC_POS_NORM: code_o = CLS_POS_NORM;
            // nine codes in a four-bit type: unused codes read as qnan
            default: code_o = CLS_QNAN;
        endcase
    end

endmodule

// ### fpexc_pipe_model.sv
`timescale 1ns/100ps
module fpexc_pipe_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic hold_i,
    input wire logic [3:0] lag_i,
    output logic older_done_o,
    output logic younger_idle_o
);
    logic [3:0] cnt_reg;

    // count cycles spent held; a slow pipeline drains late, so lag_i stretches it
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= 4'h0;
        end else if (!hold_i) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hf) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    // drained only while held and after the lag; never reports early
    assign older_done_o = hold_i && (cnt_reg >= lag_i);
    assign younger_idle_o = hold_i && (cnt_reg >= lag_i);
endmodule

// ### fpexc_pkg.sv
package fpexc_pkg;

    // ------------------------------------------------------------
    // status/control word layout (vector index = 31 - printed bit)
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int IDX_ANY_SUM = 31;
    localparam int IDX_EN_SUM = 30;
    localparam int IDX_INV_SUM = 29;
    localparam int IDX_OVF = 28;
    localparam int IDX_UNF = 27;
    localparam int IDX_DIV0 = 26;
    localparam int IDX_INEXACT = 25;
    localparam int IDX_SNAN = 24;
    localparam int IDX_ISI = 23;
    localparam int IDX_IDI = 22;
    localparam int IDX_ZDZ = 21;
    localparam int IDX_IMZ = 20;
    localparam int IDX_VC = 19;
    localparam int IDX_FR = 18;
    localparam int IDX_FI = 17;
    localparam int IDX_CLASS_HI = 16;
    localparam int IDX_CLASS_LO = 12;
    localparam int IDX_SOFT = 10;
    localparam int IDX_SQRT = 9;
    localparam int IDX_CVI = 8;
    localparam int IDX_INV_EN = 7;
    localparam int IDX_OE = 6;
    localparam int IDX_UNF_EN = 5;
    localparam int IDX_DIV0_EN = 4;
    localparam int IDX_INEXACT_EN = 3;
    localparam int IDX_NON_IEEE = 2;
    localparam int IDX_ROUND_HI = 1;
    localparam int IDX_ROUND_LO = 0;

    localparam logic [31:0] WORD_RESET = 32'h00000000;
    // computed summary bits, never written by software
    localparam logic [31:0] COMPUTED_MASK = 32'h60000000;
    // bit 20 is reserved and reads zero
    localparam logic [31:0] RESERVED_MASK = 32'h00000800;
    // invalid-operation flags: snan..vc, soft, sqrt, cvi
    localparam logic [31:0] INVALID_MASK = 32'h01f80700;
    // every sticky exception flag
    localparam logic [31:0] EXC_MASK = 32'h1ff80700;

    // ------------------------------------------------------------
    // condition vector from the datapath
    // ------------------------------------------------------------
    localparam int NCOND = 12;
    localparam int C_OVF = 0;
    localparam int C_UNF = 1;
    localparam int C_DIV0 = 2;
    localparam int C_INEXACT = 3;
    localparam int C_SNAN = 4;
    localparam int C_ISI = 5;
    localparam int C_IDI = 6;
    localparam int C_ZDZ = 7;
    localparam int C_IMZ = 8;
    localparam int C_VC = 9;
    localparam int C_SQRT = 10;
    localparam int C_CVI = 11;
    localparam logic [11:0] C_INVALID_MASK = 12'hff0;

    // rounding modes
    localparam logic [1:0] ROUND_NEAREST = 2'h0;
    localparam logic [1:0] ROUND_ZERO = 2'h1;
    localparam logic [1:0] ROUND_PLUS_INF = 2'h2;
    localparam logic [1:0] ROUND_MINUS_INF = 2'h3;

    // trap mode value meaning ignore exceptions
    localparam logic [1:0] TRAP_IGNORE = 2'h0;

    // result class codes
    localparam logic [4:0] CLS_QNAN = 5'h11;
    localparam logic [4:0] CLS_NEG_INF = 5'h09;
    localparam logic [4:0] CLS_NEG_NORM = 5'h08;
    localparam logic [4:0] CLS_NEG_DENORM = 5'h18;
    localparam logic [4:0] CLS_NEG_ZERO = 5'h12;
    localparam logic [4:0] CLS_POS_ZERO = 5'h02;
    localparam logic [4:0] CLS_POS_DENORM = 5'h14;
    localparam logic [4:0] CLS_POS_NORM = 5'h04;
    localparam logic [4:0] CLS_POS_INF = 5'h05;

    typedef enum logic [3:0] {
        FPEXC_QNAN,
        FPEXC_NEG_INF,
        FPEXC_NEG_NORM,
        FPEXC_NEG_DENORM,
        FPEXC_NEG_ZERO,
        FPEXC_POS_ZERO,
        FPEXC_POS_DENORM,
        FPEXC_POS_NORM,
        FPEXC_POS_INF
    } fpexc_class_e;

    // map the condition vector onto status word positions
    function automatic logic [31:0] cond_to_word(input logic [11:0] c);
        logic [31:0] w;
        w = 32'h00000000;
        w[IDX_OVF] = c[C_OVF];
        w[IDX_UNF] = c[C_UNF];
        w[IDX_DIV0] = c[C_DIV0];
        w[IDX_INEXACT] = c[C_INEXACT];
        w[IDX_SNAN] = c[C_SNAN];
        w[IDX_ISI] = c[C_ISI];
        w[IDX_IDI] = c[C_IDI];
        w[IDX_ZDZ] = c[C_ZDZ];
        w[IDX_IMZ] = c[C_IMZ];
        w[IDX_VC] = c[C_VC];
        w[IDX_SQRT] = c[C_SQRT];
        w[IDX_CVI] = c[C_CVI];
        return w;
    endfunction

    // or of all flags masked by their enables
    function automatic logic enabled_any(input logic [31:0] w);
        return ((|(w & INVALID_MASK)) & w[IDX_INV_EN]) | (w[IDX_OVF] & w[IDX_OE])
            | (w[IDX_UNF] & w[IDX_UNF_EN]) | (w[IDX_DIV0] & w[IDX_DIV0_EN])
            | (w[IDX_INEXACT] & w[IDX_INEXACT_EN]);
    endfunction

endpackage

// ### fpexc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - sticky bad integer convert flag at bit 23
// - five exception enables at bits 24 to 28
// - non ieee select bit at 29
// - rounding field bits 30-31 selects mode
// - class codes for qnan and infinities
// - class codes for negative normal, denormals
// - assist exception needs enable and nonzero trap
// - flags set regardless of enables or trap
// - any summary sets on flag rise or write
// - enabled summary follows flags masked by enables
// - inexact may set with overflow or underflow
// - snan may pair with imz, vc, cvi
// - enabled invalid or divide-by-zero suppresses write
// - other conditions deliver result to destination
// - enable picks trap result, else default
// - no handler for disabled or ignore mode
// - handler waits older done, younger not executed
// - ignore mode: sync records earlier deferred flags
// - underflow enable does not steer store denorm
// - computed summaries not writable by software
module fpexc_top (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    // move-to-status port: bitwise masked write of the word
    input wire logic WR_EN_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic [31:0] WR_MASK_I,
    output logic [31:0] RD_DATA_O,
    // instruction completion from the datapath
    input wire logic INSTR_VALID_I,
    input wire logic [fpexc_pkg::NCOND-1:0] EXC_COND_I,
    input wire fpexc_pkg::fpexc_class_e RESULT_CLASS_I,
    input wire logic FRAC_ROUNDED_I,
    input wire logic FRAC_INEXACT_I,
    input wire logic SYNC_I,
    input wire logic STORE_TINY_I,
    // machine-state trap mode and pipeline state
    input wire logic [1:0] TRAP_MODE_I,
    input wire logic OLDER_DONE_I,
    input wire logic YOUNGER_IDLE_I,
    output logic SUPPRESS_O,
    output logic WRITE_RESULT_O,
    output logic TRAP_RESULT_O,
    output logic HOLD_YOUNGER_O,
    output logic ASSIST_EXC_O,
    output logic [1:0] ROUND_MODE_O,
    output logic NON_IEEE_O,
    output logic STORE_DENORM_O
);
    import fpexc_pkg::*;

    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic [31:0] defer_reg;
    logic [31:0] defer_next;
    logic pend_reg;
    logic pend_next;
    logic assist_reg;
    logic assist_next;
    logic [4:0] class_code;
    logic [31:0] cond_word;
    logic ignore_mode;
    logic inv_occ;
    logic en_occ;
    logic supp;

    // ------------------------------------------------------------
    // condition decode
    // ------------------------------------------------------------
    fpexc_class_enc u_class (
        .class_i(RESULT_CLASS_I),
        .code_o(class_code)
    );

    // several condition bits may arrive together from one instruction
    assign cond_word = cond_to_word(EXC_COND_I);
    assign ignore_mode = (TRAP_MODE_I == TRAP_IGNORE);
    assign inv_occ = |(EXC_COND_I & C_INVALID_MASK);
    // enables come from the stored word, never from pending writes
    // a same-cycle write of an enable only counts from the next instruction
    assign en_occ = (inv_occ & word_reg[IDX_INV_EN])
        | (EXC_COND_I[C_OVF] & word_reg[IDX_OE])
        | (EXC_COND_I[C_UNF] & word_reg[IDX_UNF_EN])
        | (EXC_COND_I[C_DIV0] & word_reg[IDX_DIV0_EN])
        | (EXC_COND_I[C_INEXACT] & word_reg[IDX_INEXACT_EN]);
    // only these two lose an operand if the result were written
    assign supp = (inv_occ & word_reg[IDX_INV_EN])
        | (EXC_COND_I[C_DIV0] & word_reg[IDX_DIV0_EN]);

    // ------------------------------------------------------------
    // result delivery controls
    // ------------------------------------------------------------
    // suppress, write and trap result combinational with the completing instruction; hold and assist registered
    assign SUPPRESS_O = INSTR_VALID_I & supp;
    assign WRITE_RESULT_O = INSTR_VALID_I & ~supp;
    assign TRAP_RESULT_O = INSTR_VALID_I & en_occ;
    assign HOLD_YOUNGER_O = pend_reg;
    assign ASSIST_EXC_O = assist_reg;
    assign RD_DATA_O = word_reg;
    assign ROUND_MODE_O = word_reg[IDX_ROUND_HI:IDX_ROUND_LO];
    assign NON_IEEE_O = word_reg[IDX_NON_IEEE];
    // store denormalization follows tininess only, not the underflow enable
    assign STORE_DENORM_O = STORE_TINY_I;

    // ------------------------------------------------------------
    // status/control word next state
    // ------------------------------------------------------------
    // flags are applied after the software write, so a set beats a clear
    always_comb begin
        logic [31:0] w;
        logic [31:0] rec;
        logic [31:0] wmask;
        w = word_reg;
        rec = 32'h00000000;
        wmask = WR_MASK_I & ~COMPUTED_MASK & ~RESERVED_MASK;
        defer_next = defer_reg;
        if (WR_EN_I) begin
            w = (w & ~wmask) | (WR_DATA_I & wmask);
        end
        // in ignore mode flags wait in defer_reg until sync
        if (ignore_mode) begin
            if (SYNC_I) begin
                rec = defer_reg | (INSTR_VALID_I ? cond_word : 32'h00000000);
                defer_next = 32'h00000000;
            end else if (INSTR_VALID_I) begin
                defer_next = defer_reg | cond_word;
            end
        end else begin
            rec = (INSTR_VALID_I ? cond_word : 32'h00000000) | defer_reg;
            defer_next = 32'h00000000;
        end
        // the summary only fires on a zero-to-one change of a flag
        if (|(rec & ~w & EXC_MASK)) begin
            w[IDX_ANY_SUM] = 1'b1;
        end
        w = w | (rec & EXC_MASK);
        if (INSTR_VALID_I && !SYNC_I) begin
            if (supp) begin
                // suppressed: rounding bits cleared, class left as it was
                w[IDX_FR] = 1'b0;
                w[IDX_FI] = 1'b0;
            end else begin
                w[IDX_FR] = FRAC_ROUNDED_I;
                w[IDX_FI] = FRAC_INEXACT_I;
                w[IDX_CLASS_HI:IDX_CLASS_LO] = class_code;
            end
        end
        w = w & ~RESERVED_MASK;
        w[IDX_INV_SUM] = |(w & INVALID_MASK);
        w[IDX_EN_SUM] = enabled_any(w);
        word_next = w;
    end

    // ------------------------------------------------------------
    // assist exception sequencing
    // ------------------------------------------------------------
    // the handler is held off until the pipeline is precise
    always_comb begin
        pend_next = pend_reg;
        assist_next = 1'b0;
        if (pend_reg && OLDER_DONE_I && YOUNGER_IDLE_I) begin
            assist_next = 1'b1;
            pend_next = 1'b0;
        end
        // arming comes after the release, so a new condition is never lost
        if (INSTR_VALID_I && en_occ && !ignore_mode) begin
            pend_next = 1'b1;
        end
    end

    // registers
    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            word_reg <= WORD_RESET;
            defer_reg <= 32'h00000000;
            pend_reg <= 1'b0;
            assist_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            defer_reg <= defer_next;
            pend_reg <= pend_next;
            assist_reg <= assist_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RESET_I);

    // control fields and the sticky convert flag
    a_cvi_sticky: assert property (
        word_reg[IDX_CVI] && !(WR_EN_I && WR_MASK_I[IDX_CVI]) |=> word_reg[IDX_CVI]
    ) else $error("convert flag lost without a write");

    a_cvi_record: assert property (
        INSTR_VALID_I && !ignore_mode && EXC_COND_I[C_CVI] |=> word_reg[IDX_CVI]
    ) else $error("convert flag not recorded");

    a_enable_write: assert property (
        WR_EN_I && WR_MASK_I[IDX_DIV0_EN]
            |=> word_reg[IDX_DIV0_EN] == $past(WR_DATA_I[IDX_DIV0_EN])
    ) else $error("zero divide enable not written");

    a_non_ieee_write: assert property (
        WR_EN_I && WR_MASK_I[IDX_NON_IEEE]
            |=> NON_IEEE_O == $past(WR_DATA_I[IDX_NON_IEEE])
    ) else $error("non ieee select not written");

    a_round_write: assert property (
        WR_EN_I && WR_MASK_I[IDX_ROUND_HI] && WR_MASK_I[IDX_ROUND_LO]
            |=> ROUND_MODE_O == $past(WR_DATA_I[IDX_ROUND_HI:IDX_ROUND_LO])
    ) else $error("rounding field not written");

    // result class codes, checked against the constants, not the encoder
    a_class_qnan: assert property (
        INSTR_VALID_I && !SYNC_I && !supp && (RESULT_CLASS_I == FPEXC_QNAN)
            |=> word_reg[IDX_CLASS_HI:IDX_CLASS_LO] == CLS_QNAN
    ) else $error("quiet nan class code wrong");

    a_class_neg_denorm: assert property (
        INSTR_VALID_I && !SYNC_I && !supp && (RESULT_CLASS_I == FPEXC_NEG_DENORM)
            |=> word_reg[IDX_CLASS_HI:IDX_CLASS_LO] == CLS_NEG_DENORM
    ) else $error("negative denormal class code wrong");

    a_class_pos_zero: assert property (
        INSTR_VALID_I && !SYNC_I && !supp && (RESULT_CLASS_I == FPEXC_POS_ZERO)
            |=> word_reg[IDX_CLASS_HI:IDX_CLASS_LO] == CLS_POS_ZERO
    ) else $error("positive zero class code wrong");

    // summaries and flag recording
    a_invalid_summary: assert property (
        word_reg[IDX_INV_SUM] == (|(word_reg & INVALID_MASK))
    ) else $error("invalid summary mismatch");

    a_enabled_summary: assert property (
        word_reg[IDX_EN_SUM] == enabled_any(word_reg)
    ) else $error("enabled summary mismatch");

    a_flag_independent: assert property (
        INSTR_VALID_I && !ignore_mode && EXC_COND_I[C_OVF] |=> word_reg[IDX_OVF]
    ) else $error("overflow flag not recorded");

    a_any_rise: assert property (
        INSTR_VALID_I && !ignore_mode && (|(cond_word & ~word_reg & EXC_MASK))
            && !WR_EN_I |=> word_reg[IDX_ANY_SUM]
    ) else $error("any summary not set on flag rise");

    // result delivery
    a_zdiv_suppress: assert property (
        INSTR_VALID_I && EXC_COND_I[C_DIV0] && word_reg[IDX_DIV0_EN]
            |-> SUPPRESS_O && !WRITE_RESULT_O
    ) else $error("enabled divide by zero not suppressed");

    a_write_exclusive: assert property (
        INSTR_VALID_I |-> WRITE_RESULT_O != SUPPRESS_O
    ) else $error("result neither written nor suppressed");

    a_trap_result: assert property (
        INSTR_VALID_I && EXC_COND_I[C_OVF] && word_reg[IDX_OE] |-> TRAP_RESULT_O
    ) else $error("enabled overflow without trap result");

    // handler sequencing
    a_ignore_no_trap: assert property (
        ignore_mode && !pend_reg |=> !pend_reg ##1 !ASSIST_EXC_O
    ) else $error("handler armed in ignore mode");

    a_disabled_no_arm: assert property (
        INSTR_VALID_I && !en_occ && !pend_reg |=> !HOLD_YOUNGER_O
    ) else $error("handler armed by disabled condition");

    a_trap_precise: assert property (
        ASSIST_EXC_O |-> $past(pend_reg && OLDER_DONE_I && YOUNGER_IDLE_I)
    ) else $error("handler raised before pipeline precise");

    a_hold_release: assert property (
        pend_reg && OLDER_DONE_I && YOUNGER_IDLE_I |=> ASSIST_EXC_O
    ) else $error("precise pipeline did not raise assist");

    a_trap_raise: assert property (
        INSTR_VALID_I && en_occ && !ignore_mode |=> HOLD_YOUNGER_O
    ) else $error("enabled condition did not arm assist");

    a_sync_flush: assert property (
        ignore_mode && SYNC_I |=> (word_reg & $past(defer_reg)) == $past(defer_reg)
    ) else $error("deferred flags not recorded on sync");

endmodule
